// ### dsrb_regs.vh
// register offsets, field positions and reset values of the domain soft reset bank
`ifndef DSRB_REGS_VH
`define DSRB_REGS_VH

`define DSRB_PK_OFS      12'h080
`define DSRB_FE_OFS      12'h084
`define DSRB_FC_OFS      12'h088
`define DSRB_CG_OFS      12'h08c
`define DSRB_AU_OFS      12'h090
`define DSRB_FM_OFS      12'h094

`define DSRB_PK_W        7
`define DSRB_FE_W        2
`define DSRB_FC_W        6
`define DSRB_CG_W        3
`define DSRB_AU_W        8
`define DSRB_FM_W        2

`define DSRB_PK_RST      7'h00
`define DSRB_FE_RST      2'h0
`define DSRB_FC_RST      6'h3f
`define DSRB_CG_RST      3'h0
`define DSRB_AU_RST      8'h00
`define DSRB_FM_RST      2'h0

`define DSRB_PK_GP_BIT   6
`define DSRB_PK_AF0_BIT  4
`define DSRB_FE_X4_BIT   0
`define DSRB_FE_X1_BIT   1
`define DSRB_CG_TMR_BIT  0
`define DSRB_CG_GP_BIT   1
`define DSRB_CG_CFG_BIT  2
`define DSRB_AU_I2S_BIT  7
`define DSRB_FM_BRG_BIT  0
`define DSRB_FM_AF1_BIT  1

`endif

// ### dsrb_rst_cell.v
// one reset output: asserts at once from its control bit, releases through two flops
`timescale 1ns/1ps
module dsrb_rst_cell (
	input  wire sys_clk,
	input  wire rstn,
	input  wire ctl_bit,
	output wire rst_out
);

	reg sync1_reg;
	reg sync2_reg;

	// ctl_bit high sets the flops to one without a clock; release is clocked by sys_clk
	wire clr_n = rstn & ~ctl_bit;

	always @(posedge sys_clk or negedge clr_n) begin
		if (!clr_n) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else begin
			sync1_reg <= 1'b0;
			sync2_reg <= sync1_reg;
		end
	end

	assign rst_out = ctl_bit | sync2_reg;

endmodule

// ### dsrb_top.v
// domain soft reset bank: apb register file and per-domain reset outputs
//
// Overview of operation
// (RULE1) each functional domain has its own soft reset bit; writing one asserts it
// (RULE2) reset output goes active immediately when its bit is written one
// (RULE3) writing zero releases the reset synchronously on the free-running bank clock
// (RULE4) reset stays until firmware writes zero; hardware never clears bits
// (RULE5) general purpose reserved bits are plain storage, driving no reset
// (RULE6) packet fifo bits 0-5 reset fifos, async fifo 0, peripheral; bit 4 also secondary
// (RULE7) engine bit 0 fast part, bit 1 single-rate part; both reset secondary domain
// (RULE8) config group bit 2 resets state machine, serial master, fifo, dma, ahb master
// (RULE9) config group bit 0 resets periodic timer; bit 1 is general purpose storage
// (RULE10) audio bit 7 resets only the i2s bus interface, not the external audio path
// (RULE11) firmware should power cycle the i2s domain for a full reset
// (RULE12) audio bits 0-5 reset audio domains 0-5; bit 6 resets audio dma domain
// (RULE13) fabric misc bit 0 resets bridge domain, bit 1 async fifo one domain
// (RULE14) fabric clock domain resets 0, 2, 4, 5 come out of system reset asserted
`timescale 1ns/1ps
`include "dsrb_regs.vh"
module dsrb_top #(
	parameter ADDR_W = 12
) (
	input  wire              sys_clk,
	input  wire              rstn,
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [ADDR_W-1:0] paddr,
	input  wire [31:0]       pwdata,
	input  wire [3:0]        pstrb,
	output wire              pready,
	output reg  [31:0]       prdata,
	output wire              pslverr,
	output wire [5:0]        packet_fifo_domain_rst,
	output wire              packet_secondary_domain_rst,
	output wire              fusion_engine_fast_rst,
	output wire              fusion_engine_single_rst,
	output wire              engine_secondary_domain_rst,
	output wire              fabric_domain_c02_rst,
	output wire              fabric_domain_c09_rst,
	output wire              fabric_domain_c16_rst,
	output wire              fabric_domain_c21_rst,
	output wire              simple_periodic_timer_rst,
	output wire              config_state_machine_rst,
	output wire [5:0]        audio_domain_rst,
	output wire              audio_dma_domain_rst,
	output wire              audio_bus_interface_rst,
	output wire              bridge_domain_rst,
	output wire              async_fifo_one_domain_rst
);

	//------------------------------------------------------------
	// apb decode
	//------------------------------------------------------------
	localparam SEL_NONE = 3'h0;
	localparam SEL_PK   = 3'h1;
	localparam SEL_FE   = 3'h2;
	localparam SEL_FC   = 3'h3;
	localparam SEL_CG   = 3'h4;
	localparam SEL_AU   = 3'h5;
	localparam SEL_FM   = 3'h6;

	// register select from the byte address; anything else is unmapped
	function [2:0] dec_sel;
		input [ADDR_W-1:0] a;
		begin
			if (a == `DSRB_PK_OFS) begin
				dec_sel = SEL_PK;
			end else if (a == `DSRB_FE_OFS) begin
				dec_sel = SEL_FE;
			end else if (a == `DSRB_FC_OFS) begin
				dec_sel = SEL_FC;
			end else if (a == `DSRB_CG_OFS) begin
				dec_sel = SEL_CG;
			end else if (a == `DSRB_AU_OFS) begin
				dec_sel = SEL_AU;
			end else if (a == `DSRB_FM_OFS) begin
				dec_sel = SEL_FM;
			end else begin
				dec_sel = SEL_NONE;
			end
		end
	endfunction

	// zero-extends a field of up to eight bits to a bus word
	function [31:0] rd_word;
		input [7:0] f;
		begin
			rd_word = {24'h000000, f};
		end
	endfunction

	wire [2:0] sel      = dec_sel(paddr);
	wire       access   = psel & penable;
	wire       wr_en    = access & pwrite & pstrb[0];
	wire       rd_setup = psel & ~penable & ~pwrite;

	// zero wait states; unmapped accesses read zero and flag an error
	assign pready  = 1'b1;
	assign pslverr = access & (sel == SEL_NONE);

	//------------------------------------------------------------
	// field write enables
	//------------------------------------------------------------
	// all fields sit in byte 0, so only its strobe gates a write
	wire       wr_pk    = wr_en & (sel == SEL_PK);
	wire       wr_fe    = wr_en & (sel == SEL_FE);
	wire       wr_fc    = wr_en & (sel == SEL_FC);
	wire       wr_cg    = wr_en & (sel == SEL_CG);
	wire       wr_au    = wr_en & (sel == SEL_AU);
	wire       wr_fm    = wr_en & (sel == SEL_FM);

	//------------------------------------------------------------
	// control registers
	//------------------------------------------------------------
	// bits change only on firmware writes, never by hardware (see RULE4)
	reg [`DSRB_PK_W-1:0] pk_reg;
	reg [`DSRB_FE_W-1:0] fe_reg;
	reg [`DSRB_FC_W-1:0] fc_reg;
	reg [`DSRB_CG_W-1:0] cg_reg;
	reg [`DSRB_AU_W-1:0] au_reg;
	reg [`DSRB_FM_W-1:0] fm_reg;

	// packet fifo domains; bit 6 is plain storage (see RULE5)
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pk_reg <= `DSRB_PK_RST;
		end else if (wr_pk) begin
			pk_reg <= pwdata[`DSRB_PK_W-1:0]; // see RULE1
		end
	end

	// fusion engine fast and single-rate parts
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fe_reg <= `DSRB_FE_RST;
		end else if (wr_fe) begin
			fe_reg <= pwdata[`DSRB_FE_W-1:0];
		end
	end

	// fabric clock domains, asserted out of reset; bits 1 and 3 are storage
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fc_reg <= `DSRB_FC_RST; // see RULE14
		end else if (wr_fc) begin
			fc_reg <= pwdata[`DSRB_FC_W-1:0];
		end
	end

	// configuration group; bit 1 is storage (see RULE9)
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cg_reg <= `DSRB_CG_RST;
		end else if (wr_cg) begin
			cg_reg <= pwdata[`DSRB_CG_W-1:0];
		end
	end

	// audio domains, audio dma and the i2s bus side
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			au_reg <= `DSRB_AU_RST;
		end else if (wr_au) begin
			au_reg <= pwdata[`DSRB_AU_W-1:0];
		end
	end

	// bridge and async fifo one domains
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fm_reg <= `DSRB_FM_RST;
		end else if (wr_fm) begin
			fm_reg <= pwdata[`DSRB_FM_W-1:0];
		end
	end

	//------------------------------------------------------------
	// read data
	//------------------------------------------------------------
	reg [31:0] prdata_next;

	// word of the selected register, zero above its field
	always @* begin
		prdata_next = 32'h00000000;
		if (sel == SEL_PK) begin
			prdata_next = rd_word({{(8-`DSRB_PK_W){1'b0}}, pk_reg});
		end else if (sel == SEL_FE) begin
			prdata_next = rd_word({{(8-`DSRB_FE_W){1'b0}}, fe_reg});
		end else if (sel == SEL_FC) begin
			prdata_next = rd_word({{(8-`DSRB_FC_W){1'b0}}, fc_reg});
		end else if (sel == SEL_CG) begin
			prdata_next = rd_word({{(8-`DSRB_CG_W){1'b0}}, cg_reg});
		end else if (sel == SEL_AU) begin
			prdata_next = rd_word(au_reg);
		end else if (sel == SEL_FM) begin
			prdata_next = rd_word({{(8-`DSRB_FM_W){1'b0}}, fm_reg});
		end
	end

	// loaded in the setup cycle so it stands through the access phase
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			prdata <= prdata_next;
		end
	end

	//------------------------------------------------------------
	// reset cells
	//------------------------------------------------------------
	// one cell per reset-driving bit; storage bits get none (see RULE5 see RULE9)
	localparam PK_CELLS = 6;
	localparam FE_CELLS = 2;
	localparam FC_CELLS = 4;
	localparam CG_CELLS = 2;
	localparam AU_CELLS = 8;
	localparam FM_CELLS = 2;

	// control bits in cell order
	wire [PK_CELLS-1:0] pk_ctl = pk_reg[PK_CELLS-1:0];
	wire [FE_CELLS-1:0] fe_ctl = fe_reg;
	wire [FC_CELLS-1:0] fc_ctl = {fc_reg[5], fc_reg[4], fc_reg[2], fc_reg[0]};
	wire [CG_CELLS-1:0] cg_ctl = {cg_reg[`DSRB_CG_CFG_BIT], cg_reg[`DSRB_CG_TMR_BIT]};
	wire [AU_CELLS-1:0] au_ctl = au_reg;
	wire [FM_CELLS-1:0] fm_ctl = fm_reg;

	// reset levels in cell order
	wire [PK_CELLS-1:0] pk_rst;
	wire [FE_CELLS-1:0] fe_rst;
	wire [FC_CELLS-1:0] fc_rst;
	wire [CG_CELLS-1:0] cg_rst;
	wire [AU_CELLS-1:0] au_rst;
	wire [FM_CELLS-1:0] fm_rst;

	genvar gi;
	generate
		// packet fifo cells
		for (gi = 0; gi < PK_CELLS; gi = gi + 1) begin : g_pk
			dsrb_rst_cell u_cell (
				.sys_clk (sys_clk),
				.rstn    (rstn),
				.ctl_bit (pk_ctl[gi]), // see RULE2 see RULE3
				.rst_out (pk_rst[gi])
			);
		end

		// fusion engine cells
		for (gi = 0; gi < FE_CELLS; gi = gi + 1) begin : g_fe
			dsrb_rst_cell u_cell (
				.sys_clk (sys_clk),
				.rstn    (rstn),
				.ctl_bit (fe_ctl[gi]), // see RULE2 see RULE3
				.rst_out (fe_rst[gi])
			);
		end

		// fabric clock domain cells
		for (gi = 0; gi < FC_CELLS; gi = gi + 1) begin : g_fc
			dsrb_rst_cell u_cell (
				.sys_clk (sys_clk),
				.rstn    (rstn),
				.ctl_bit (fc_ctl[gi]), // see RULE2 see RULE3
				.rst_out (fc_rst[gi])
			);
		end

		// configuration group cells
		for (gi = 0; gi < CG_CELLS; gi = gi + 1) begin : g_cg
			dsrb_rst_cell u_cell (
				.sys_clk (sys_clk),
				.rstn    (rstn),
				.ctl_bit (cg_ctl[gi]), // see RULE2 see RULE3
				.rst_out (cg_rst[gi])
			);
		end

		// audio cells
		for (gi = 0; gi < AU_CELLS; gi = gi + 1) begin : g_au
			dsrb_rst_cell u_cell (
				.sys_clk (sys_clk),
				.rstn    (rstn),
				.ctl_bit (au_ctl[gi]), // see RULE2 see RULE3
				.rst_out (au_rst[gi])
			);
		end

		// fabric miscellaneous cells
		for (gi = 0; gi < FM_CELLS; gi = gi + 1) begin : g_fm
			dsrb_rst_cell u_cell (
				.sys_clk (sys_clk),
				.rstn    (rstn),
				.ctl_bit (fm_ctl[gi]), // see RULE2 see RULE3
				.rst_out (fm_rst[gi])
			);
		end
	endgenerate

	//------------------------------------------------------------
	// packet fifo outputs
	//------------------------------------------------------------
	assign packet_fifo_domain_rst      = pk_rst;                          // see RULE6
	assign packet_secondary_domain_rst = pk_rst[`DSRB_PK_AF0_BIT];        // see RULE6

	//------------------------------------------------------------
	// fusion engine outputs
	//------------------------------------------------------------
	assign fusion_engine_fast_rst      = fe_rst[`DSRB_FE_X4_BIT];         // see RULE7
	assign fusion_engine_single_rst    = fe_rst[`DSRB_FE_X1_BIT];         // see RULE7
	assign engine_secondary_domain_rst = fe_rst[0] | fe_rst[1];           // see RULE7

	//------------------------------------------------------------
	// fabric clock domain outputs
	//------------------------------------------------------------
	assign fabric_domain_c02_rst       = fc_rst[0];                       // see RULE14
	assign fabric_domain_c09_rst       = fc_rst[1];                       // see RULE14
	assign fabric_domain_c16_rst       = fc_rst[2];                       // see RULE14
	assign fabric_domain_c21_rst       = fc_rst[3];                       // see RULE14

	//------------------------------------------------------------
	// configuration group outputs
	//------------------------------------------------------------
	assign simple_periodic_timer_rst   = cg_rst[0];                       // see RULE9
	assign config_state_machine_rst    = cg_rst[1];                       // see RULE8

	//------------------------------------------------------------
	// audio outputs
	//------------------------------------------------------------
	assign audio_domain_rst            = au_rst[5:0];                     // see RULE12
	assign audio_dma_domain_rst        = au_rst[6];                       // see RULE12
	// bus side of i2s only; external path has no reset here (see RULE10)
	assign audio_bus_interface_rst     = au_rst[`DSRB_AU_I2S_BIT];

	//------------------------------------------------------------
	// fabric miscellaneous outputs
	//------------------------------------------------------------
	assign bridge_domain_rst           = fm_rst[`DSRB_FM_BRG_BIT];        // see RULE13
	assign async_fifo_one_domain_rst   = fm_rst[`DSRB_FM_AF1_BIT];        // see RULE13

endmodule

// ### dsrb_sva.sv
// assertions for the domain soft reset bank
`timescale 1ns/1ps
`include "dsrb_regs.vh"
module dsrb_sva #(
	parameter ADDR_W = 12
) (
	input wire              sys_clk,
	input wire              rstn,
	input wire              psel,
	input wire              penable,
	input wire              pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0]       pwdata,
	input wire [3:0]        pstrb,
	input wire              pready,
	input wire [31:0]       prdata,
	input wire              pslverr,
	input wire [5:0]        packet_fifo_domain_rst,
	input wire              packet_secondary_domain_rst,
	input wire              fusion_engine_fast_rst,
	input wire              fusion_engine_single_rst,
	input wire              engine_secondary_domain_rst,
	input wire              fabric_domain_c02_rst,
	input wire              fabric_domain_c09_rst,
	input wire              fabric_domain_c16_rst,
	input wire              fabric_domain_c21_rst
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	wire acc = psel && penable;
	wire hit = paddr >= `DSRB_PK_OFS && paddr <= `DSRB_FM_OFS && paddr[1:0] == 2'h0;
	wire pk_a = acc && pwrite && paddr == `DSRB_PK_OFS;
	wire pk_clr = pk_a && pstrb[0] && !pwdata[0];
	wire r0 = packet_fifo_domain_rst[0];
	// bit 0 of the packet fifo register as firmware last wrote it
	reg pk_bit0;
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pk_bit0 <= 1'b0;
		end else if (pk_a && pstrb[0]) begin
			pk_bit0 <= pwdata[0];
		end
	end
	chk_pready_high: assert property (pready) else $error("pready low");
	chk_unmapped_err: assert property (acc && !hit |-> pslverr && (pwrite || prdata == 32'h0))
		else $error("unmapped access not refused");
	chk_assert_now: assert property (pk_a && pstrb[0] && pwdata[0] |=> r0)
		else $error("reset not asserted at write");
	chk_strobe_ignore: assert property (pk_a && !pstrb[0] && !r0 |=> !r0)
		else $error("write without strobe took effect");
	chk_release_hold: assert property (pk_clr && pk_bit0 |=> r0 [*2])
		else $error("reset released too early");
	chk_release_fall: assert property ($fell(r0) && $past(rstn, 3) |-> $past(pk_clr, 3))
		else $error("reset released without matching clear");
	chk_fabric_boot: assert property ($rose(rstn) |-> fabric_domain_c02_rst &&
		fabric_domain_c09_rst && fabric_domain_c16_rst && fabric_domain_c21_rst)
		else $error("fabric resets not asserted after reset");
	chk_packet_second: assert property (
		packet_secondary_domain_rst == packet_fifo_domain_rst[4])
		else $error("secondary packet reset mismatch");
	chk_fe_second: assert property (engine_secondary_domain_rst ==
		(fusion_engine_fast_rst || fusion_engine_single_rst))
		else $error("secondary engine reset mismatch");
	cover property (pk_clr && r0 ##3 !r0);
	cover property (acc && !hit);
	cover property ($rose(rstn));
endmodule
bind dsrb_top dsrb_sva #(.ADDR_W(ADDR_W)) i_dsrb_sva (.*);

// ### test_dsrb_top.sv
// self-checking bench for the domain soft reset bank
`timescale 1ns/1ps
`include "dsrb_regs.vh"
module test_dsrb_top;
	logic        sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, rd, seed = 32'h27, model [0:5];
	logic [3:0]  pstrb = 4'hf;
	wire         pready, pslverr, packet_secondary_domain_rst, fusion_engine_fast_rst;
	wire         fusion_engine_single_rst, engine_secondary_domain_rst, fabric_domain_c02_rst;
	wire         fabric_domain_c09_rst, fabric_domain_c16_rst, fabric_domain_c21_rst;
	wire         simple_periodic_timer_rst, config_state_machine_rst, audio_dma_domain_rst;
	wire         audio_bus_interface_rst, bridge_domain_rst, async_fifo_one_domain_rst;
	wire [5:0]   packet_fifo_domain_rst, audio_domain_rst;
	wire [31:0]  prdata;
	int          fail_count = 0, total_checks = 0, cycles = 0;
	localparam logic [11:0] ofs [0:5] = '{`DSRB_PK_OFS, `DSRB_FE_OFS, `DSRB_FC_OFS,
		`DSRB_CG_OFS, `DSRB_AU_OFS, `DSRB_FM_OFS};
	localparam logic [31:0] msk [0:5] = '{32'h7f, 32'h3, 32'h3f, 32'h7, 32'hff, 32'h3};
	localparam logic [31:0] rst_val [0:5] = '{32'h0, 32'h0, 32'h3f, 32'h0, 32'h0, 32'h0};
	wire [31:0]  outs = {6'h0, packet_fifo_domain_rst, packet_secondary_domain_rst,
		fusion_engine_fast_rst, fusion_engine_single_rst, engine_secondary_domain_rst,
		fabric_domain_c02_rst, fabric_domain_c09_rst, fabric_domain_c16_rst,
		fabric_domain_c21_rst, simple_periodic_timer_rst, config_state_machine_rst,
		audio_domain_rst, audio_dma_domain_rst, audio_bus_interface_rst, bridge_domain_rst,
		async_fifo_one_domain_rst};
	dsrb_top i_dsrb_top (.*);
	always #50 sys_clk = ~sys_clk;
	function logic [31:0] nxt(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function logic [31:0] exp_out();
		return {6'h0, model[0][5:0], model[0][4], model[1][0], model[1][1], |model[1][1:0],
			model[2][0], model[2][2], model[2][4], model[2][5], model[3][0], model[3][2],
			model[4][5:0], model[4][6], model[4][7], model[5][0], model[5][1]};
	endfunction
	task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task write_chk(input int i, input logic [31:0] d, input logic [3:0] s);
		if (s[0])
			model[i] = d & msk[i];
		apb(1'b1, ofs[i], d, s);
		cmp("asserted", exp_out(), exp_out() & outs);
		repeat (2) @(posedge sys_clk);
		cmp("outputs", exp_out(), outs);
		apb(1'b0, ofs[i], 32'h0, 4'hf);
		cmp("readback", model[i], rd);
	endtask
	task reset_chk();
		for (int i = 0; i < 6; i++) begin
			model[i] = rst_val[i];
			apb(1'b0, ofs[i], 32'h0, 4'hf);
			cmp("reset value", rst_val[i], rd);
		end
		cmp("reset outputs", exp_out(), outs);
	endtask
	task final_report();
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			final_report();
		end
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		reset_chk();
		for (int j = 0; j < 12; j++)
			write_chk(j % 6, j < 6 ? 32'hffffffff : 32'h0, 4'hf);
		for (int j = 0; j < 60; j++) begin
			seed = nxt(seed);
			write_chk(seed[10:8] % 6, seed, seed[15:12]);
		end
		apb(1'b0, 12'h098, 32'h0, 4'hf);
		cmp("unmapped data", 32'h0, rd);
		cmp("unmapped error", 32'h1, {31'h0, err});
		rstn <= 1'b0; // full reset by system reset, not soft bits
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		reset_chk();
		final_report();
	end
endmodule
